// [dv/tb_timer_pin_route_select.sv]
// Testbench: register access, routing of every select code, reset and deep-standby retention
`timescale 1ns/1ps
`default_nettype none
module tb_timer_pin_route_select;
    import tprs_pkg::*;
    logic        clock, rst_b, deep_standby_rst, reg_wr, reg_rd, inv;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [7:0]  timer_io_a_out, timer_io_a_in, timer_io_b_in;
    logic [23:0] pin_a_in, pin_a_out, pin_a_oe, pin_b_in;
    logic [4:0]  hot;
    int          errors, check_count;

    tprs_top i_dut (.clock(clock), .rst_b(rst_b), .deep_standby_rst(deep_standby_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_io_a_out(timer_io_a_out), .timer_io_a_in(timer_io_a_in), .timer_io_b_in(timer_io_b_in),
        .pin_a_in(pin_a_in), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_in(pin_b_in));
    tprs_pin_model i_pins (.hot(hot), .inv(inv), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .timer_io_a_out(timer_io_a_out), .pin_a_in(pin_a_in), .pin_b_in(pin_b_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rdr(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rdr
    task automatic t_mask;
        wr(4'h0, 32'hFFFFFFFF);
        rdr(4'h0, rd);
        chk(rd, 32'h3F3C3F3C, "low reserved bits");
        wr(4'h4, 32'hFFFFFFFF);
        wr(4'h8, 32'h00000000);
        rdr(4'h4, rd);
        chk(rd, 32'h3F3C3F3C, "high reserved bits");
        rdr(4'h8, rd);
        chk(rd, 32'h00000000, "unmapped read");
        $display("test mask done");
    endtask : t_mask
    task automatic t_route;
        int          lsb, opt;
        logic [31:0] w;
        logic [3:0]  a;
        for (int c = 0; c < 8; c++) begin
            for (int s = 0; s < 4; s++) begin
                for (int v = 0; v < 2; v++) begin
                    // Clear the other route word so its channels drive no pin during this channel's checks
                    if (s == 0 && v == 0) wr((c < 4) ? 4'h4 : 4'h0, 32'h00000000);
                    a   = (c < 4) ? 4'h0 : 4'h4;
                    lsb = (c % 4) * 8;
                    opt = (s == 3) ? 2 : ((s == 2) ? 1 : 0);
                    hot = 5'(c * 3 + opt);
                    inv = v[0];
                    w   = (32'(s) << (lsb + 4)) | ((c % 2) ? (32'(s) << lsb) : 32'h0);
                    wr(a, w);
                    chk(timer_io_b_in[c], !inv, "b input");
                    chk(timer_io_a_in[c], (c % 2) ? !inv : 1'b0, "a input");
                    chk(pin_a_oe, 24'h0, "a idle");
                    w = w | (32'(s) << (lsb + 2));
                    wr(a, w);
                    chk(pin_a_oe, (s == 0) ? 24'h0 : (24'h000001 << (c * 3 + s - 1)), "a enable");
                    chk(pin_a_out[c * 3 + ((s == 0) ? 0 : s - 1)] | (s == 0), 1'b1 ^ inv | (s == 0), "a drive");
                    chk(timer_io_a_in[c], (c % 2 && s == 0) ? !inv : 1'b0, "a input ignored");
                    rdr(a, rd);
                    chk(rd, w, "read back");
                end
            end
        end
        $display("test route done");
    endtask : t_route
    task automatic t_retain;
        wr(4'h4, 32'h3B2C1B24);
        deep_standby_rst <= 1'b1;
        repeat (4) @(posedge clock);
        deep_standby_rst <= 1'b0;
        rdr(4'h4, rd);
        chk(rd, 32'h3B2C1B24, "deep standby kept");
        rst_b <= 1'b0;
        @(posedge clock);
        rst_b <= 1'b1;
        rdr(4'h4, rd);
        chk(rd, 32'h00000000, "reset clears");
        chk(pin_a_oe, 24'h0, "reset enables");
        $display("test retain done");
    endtask : t_retain
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        // Bound is some 45 times the expected run length of about 441 clock cycles
        #(25 * 20000);
        errors++;
        tally_and_finish();
    end
    initial begin
        {rst_b, deep_standby_rst, reg_wr, reg_rd, inv} = 5'h00;
        reg_addr  = 4'h0;
        reg_wdata = 32'h00000000;
        hot       = 5'h00;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        rdr(4'h0, rd);
        chk(rd, 32'h00000000, "reset value");
        t_mask();
        t_route();
        t_retain();
        tally_and_finish();
    end
endmodule : tb_timer_pin_route_select
`default_nettype wire

// [dv/tprs_pin_model.sv]
// Partner model: timer channel outputs and package pin levels around the router
`timescale 1ns/1ps
`default_nettype none
module tprs_pin_model (
    input  wire logic [4:0]  hot,
    input  wire logic        inv,
    input  wire logic [23:0] pin_a_out,
    input  wire logic [23:0] pin_a_oe,
    output logic      [7:0]  timer_io_a_out,
    output logic      [23:0] pin_a_in,
    output logic      [23:0] pin_b_in
);
    logic [23:0] lvl;
    always_comb begin
        // One pin differs from all others, so a wrong option choice shows up
        lvl            = {24{inv}} ^ (24'h000001 << hot);
        timer_io_a_out = {8{~inv}};
        pin_b_in       = lvl;
        // Pins are in peripheral mode and no other function drives them
        pin_a_in       = (pin_a_oe & pin_a_out) | (~pin_a_oe & lvl);
    end
endmodule : tprs_pin_model
`default_nettype wire

// [hdl/tprs_in_mux.sv]
// One-of-three pin option selector for a timer input
`timescale 1ns/1ps
`default_nettype none
module tprs_in_mux
    import tprs_pkg::*;
(
    input  wire logic [tprs_pkg::TPRS_SEL_W-1:0] sel,
    input  wire logic [tprs_pkg::TPRS_OPTS-1:0]  pin_in,
    output logic                                 timer_in
);
    always_comb begin
        unique case (sel)
            TPRS_SEL_OPT1: timer_in = pin_in[1];
            TPRS_SEL_OPT2: timer_in = pin_in[2];
            default:       timer_in = pin_in[0];  // 00 and 01 both pick option 0
        endcase
    end
endmodule : tprs_in_mux
`default_nettype wire

// [hdl/tprs_out_mux.sv]
// Timer output steering onto one of three pin options
`timescale 1ns/1ps
`default_nettype none
module tprs_out_mux
    import tprs_pkg::*;
(
    input  wire logic [tprs_pkg::TPRS_SEL_W-1:0] sel,
    input  wire logic                            timer_out,
    output logic      [tprs_pkg::TPRS_OPTS-1:0]  pin_out,
    output logic      [tprs_pkg::TPRS_OPTS-1:0]  pin_oe
);
    always_comb begin
        pin_oe = '0;
        unique case (sel)
            TPRS_SEL_OFF:  pin_oe = '0;
            TPRS_SEL_OPT0: pin_oe[0] = 1'b1;
            TPRS_SEL_OPT1: pin_oe[1] = 1'b1;
            TPRS_SEL_OPT2: pin_oe[2] = 1'b1;
        endcase
        pin_out = pin_oe & {TPRS_OPTS{timer_out}};
    end
endmodule : tprs_out_mux
`default_nettype wire

// [hdl/tprs_pkg.sv]
// Package: register map, field layout and encodings of the timer pin route select block
package tprs_pkg;
    localparam int          TPRS_AW            = 4;
    localparam int          TPRS_DW            = 32;
    localparam int          TPRS_GROUPS        = 2;
    localparam int          TPRS_CH_PER_GROUP  = 4;
    localparam int          TPRS_OPTS          = 3;
    localparam int          TPRS_SEL_W         = 2;
    // Register byte addresses
    localparam logic [3:0]  TPRS_OFS_ROUTE_LO  = 4'h0;
    localparam logic [3:0]  TPRS_OFS_ROUTE_HI  = 4'h4;
    // Field positions, even channel slot 0 and 2, odd slot 1 and 3
    localparam int          TPRS_SLOT_STRIDE   = 8;
    localparam int          TPRS_B_IN_LSB      = 4;
    localparam int          TPRS_A_OUT_LSB     = 2;
    localparam int          TPRS_A_IN_LSB      = 0;
    localparam logic [31:0] TPRS_WRITE_MASK    = 32'h3F3C3F3C;
    localparam logic [31:0] TPRS_RESET_VALUE   = 32'h00000000;
    // Select encodings
    localparam logic [1:0]  TPRS_SEL_OFF       = 2'h0;
    localparam logic [1:0]  TPRS_SEL_OPT0      = 2'h1;
    localparam logic [1:0]  TPRS_SEL_OPT1      = 2'h2;
    localparam logic [1:0]  TPRS_SEL_OPT2      = 2'h3;
endpackage : tprs_pkg

// [hdl/tprs_top.sv]
// Timer pin route select: two routing registers steering channels 8..15 to pin options
//
// How it works
// - Channel 11 fields: B input 29:28, A output 27:26, A input 25:24.
// - Channel 10 fields: B input 21:20, A output 19:18, no A input.
// - Channel 9 fields: B input 13:12, A output 11:10, A input 9:8.
// - Channel 8 fields: B input 5:4, A output 3:2, no A input.
// - Reserved ranges always read zero; software writes them as zero.
// - B input select: 00/01 option 0, 10 option 1, 11 option 2.
// - A output select: 00 drives nothing, 01/10/11 drive option 0/1/2.
// - Odd A input select: 00/01 option 0, 10 option 1, 11 option 2.
// - Select fields reset to 00 and read back as last written.
// - Even A output only, odd A both ways, B input only.
// - Odd A output nonzero makes it an output; its input select is ignored.
// - Deep-standby reset leaves both routing registers untouched.
// - An input pin may carry back another function's output to the timer.
// - First register serves channels 8 to 11 only.
// - Second register serves channels 12 to 15 with the same layout.
`timescale 1ns/1ps
`default_nettype none
module tprs_top
    import tprs_pkg::*;
#(
    parameter int CHANNELS = tprs_pkg::TPRS_GROUPS * tprs_pkg::TPRS_CH_PER_GROUP
)
(
    input  wire logic                                       clock,
    input  wire logic                                       rst_b,
    input  wire logic                                       deep_standby_rst,
    input  wire logic [tprs_pkg::TPRS_AW-1:0]               reg_addr,
    input  wire logic [tprs_pkg::TPRS_DW-1:0]               reg_wdata,
    input  wire logic                                       reg_wr,
    input  wire logic                                       reg_rd,
    output logic      [tprs_pkg::TPRS_DW-1:0]               reg_rdata,
    input  wire logic [CHANNELS-1:0]                        timer_io_a_out,
    output logic      [CHANNELS-1:0]                        timer_io_a_in,
    output logic      [CHANNELS-1:0]                        timer_io_b_in,
    input  wire logic [CHANNELS*tprs_pkg::TPRS_OPTS-1:0]    pin_a_in,
    output logic      [CHANNELS*tprs_pkg::TPRS_OPTS-1:0]    pin_a_out,
    output logic      [CHANNELS*tprs_pkg::TPRS_OPTS-1:0]    pin_a_oe,
    input  wire logic [CHANNELS*tprs_pkg::TPRS_OPTS-1:0]    pin_b_in
);
    import tprs_pkg::*;

    typedef struct packed {
        logic [TPRS_DW-1:0] route_lo;
        logic [TPRS_DW-1:0] route_hi;
        logic [TPRS_DW-1:0] rdata;
    } tprs_state_t;

    tprs_state_t state_r;
    tprs_state_t state_nxt;

    // Field extraction shared by every channel
    function automatic logic [TPRS_SEL_W-1:0] field_of(input logic [TPRS_DW-1:0] word,
                                                       input int slot, input int lsb);
        field_of = word[slot*TPRS_SLOT_STRIDE + lsb +: TPRS_SEL_W];
    endfunction : field_of

    always_comb begin
        state_nxt = state_r;
        state_nxt.rdata = '0;
        if (reg_wr && reg_addr == TPRS_OFS_ROUTE_LO) begin
            state_nxt.route_lo = reg_wdata & TPRS_WRITE_MASK;
        end
        if (reg_wr && reg_addr == TPRS_OFS_ROUTE_HI) begin
            state_nxt.route_hi = reg_wdata & TPRS_WRITE_MASK;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                TPRS_OFS_ROUTE_LO: state_nxt.rdata = state_r.route_lo;
                TPRS_OFS_ROUTE_HI: state_nxt.rdata = state_r.route_hi;
                default:           state_nxt.rdata = '0;
            endcase
        end
    end

    // Deep-standby reset is not a reset for this state, so it is never consulted
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_r.route_lo <= TPRS_RESET_VALUE;
            state_r.route_hi <= TPRS_RESET_VALUE;
            state_r.rdata    <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign reg_rdata = state_r.rdata;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            localparam int SLOT = ch % TPRS_CH_PER_GROUP;
            localparam bit ODD  = (ch % 2) == 1;
            logic [TPRS_DW-1:0]    word;
            logic [TPRS_SEL_W-1:0] b_sel;
            logic [TPRS_SEL_W-1:0] a_out_sel;
            logic [TPRS_SEL_W-1:0] a_in_sel;
            logic                  a_in_raw;
            assign word      = (ch < TPRS_CH_PER_GROUP) ? state_r.route_lo : state_r.route_hi;
            assign b_sel     = field_of(word, SLOT, TPRS_B_IN_LSB);
            assign a_out_sel = field_of(word, SLOT, TPRS_A_OUT_LSB);
            assign a_in_sel  = ODD ? field_of(word, SLOT, TPRS_A_IN_LSB) : TPRS_SEL_OFF;

            tprs_in_mux u_b_in (
                .sel      (b_sel),
                .pin_in   (pin_b_in[ch*TPRS_OPTS +: TPRS_OPTS]),
                .timer_in (timer_io_b_in[ch])
            );

            tprs_out_mux u_a_out (
                .sel       (a_out_sel),
                .timer_out (timer_io_a_out[ch]),
                .pin_out   (pin_a_out[ch*TPRS_OPTS +: TPRS_OPTS]),
                .pin_oe    (pin_a_oe[ch*TPRS_OPTS +: TPRS_OPTS])
            );

            tprs_in_mux u_a_in (
                .sel      (a_in_sel),
                .pin_in   (pin_a_in[ch*TPRS_OPTS +: TPRS_OPTS]),
                .timer_in (a_in_raw)
            );

            // Input path keeps the pin level even when another function drives it
            assign timer_io_a_in[ch] = (ODD && a_out_sel == TPRS_SEL_OFF) ? a_in_raw : 1'b0;

            p_dir_excl: assert property (@(posedge clock) disable iff (!rst_b)
                (a_out_sel != TPRS_SEL_OFF) |-> !timer_io_a_in[ch])
                else $error("a input active while a output routed");
            p_oe_onehot: assert property (@(posedge clock) disable iff (!rst_b)
                $onehot0(pin_a_oe[ch*TPRS_OPTS +: TPRS_OPTS]))
                else $error("more than one a pin enabled");
        end
    endgenerate

    property p_write_lo;
        @(posedge clock) disable iff (!rst_b)
        (reg_wr && reg_addr == TPRS_OFS_ROUTE_LO) |=> state_r.route_lo == ($past(reg_wdata) & TPRS_WRITE_MASK);
    endproperty
    a_write_lo: assert property (p_write_lo) else $error("low route word not stored");

    property p_write_hi;
        @(posedge clock) disable iff (!rst_b)
        (reg_wr && reg_addr == TPRS_OFS_ROUTE_HI) |=> state_r.route_hi == ($past(reg_wdata) & TPRS_WRITE_MASK);
    endproperty
    a_write_hi: assert property (p_write_hi) else $error("high route word not stored");

    property p_rsvd_zero;
        @(posedge clock) disable iff (!rst_b)
        (reg_rdata & ~TPRS_WRITE_MASK) == '0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

    property p_readback;
        @(posedge clock) disable iff (!rst_b)
        (reg_rd && !reg_wr && reg_addr == TPRS_OFS_ROUTE_LO) |=> reg_rdata == $past(state_r.route_lo);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    property p_after_reset;
        @(posedge clock) !rst_b |=> (state_r.route_lo == TPRS_RESET_VALUE && state_r.route_hi == TPRS_RESET_VALUE);
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("routes not cleared by reset");

    property p_deep_keep;
        @(posedge clock) disable iff (!rst_b)
        (deep_standby_rst && !reg_wr) |=> $stable(state_r.route_lo) && $stable(state_r.route_hi);
    endproperty
    a_deep_keep: assert property (p_deep_keep) else $error("deep standby changed routes");

    property p_b_opt2;
        @(posedge clock) disable iff (!rst_b)
        (state_r.route_lo[29:28] == TPRS_SEL_OPT2) |-> timer_io_b_in[3] == pin_b_in[3*TPRS_OPTS + 2];
    endproperty
    a_b_opt2: assert property (p_b_opt2) else $error("ch11 b input option wrong");

    property p_a8_opt1;
        @(posedge clock) disable iff (!rst_b)
        (state_r.route_lo[3:2] == TPRS_SEL_OPT1) |-> pin_a_oe[1] && pin_a_out[1] == timer_io_a_out[0];
    endproperty
    a_a8_opt1: assert property (p_a8_opt1) else $error("ch8 a output option wrong");
endmodule : tprs_top
`default_nettype wire
